// ===== design/fscp_consts.vh
// Constants for the flash status, configuration and protection block.
`ifndef FSCP_CONSTS_VH
`define FSCP_CONSTS_VH

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define FSCP_OP_WR_ENABLE 8'h06
`define FSCP_OP_WR_DISABLE 8'h04
`define FSCP_OP_WR_STAT1 8'h01
`define FSCP_OP_WR_STAT2 8'h31
`define FSCP_OP_WR_STAT3 8'h11
`define FSCP_OP_RD_STAT1 8'h05
`define FSCP_OP_RD_STAT2 8'h35
`define FSCP_OP_RD_STAT3 8'h15
`define FSCP_OP_SUSPEND 8'h75
`define FSCP_OP_RESUME 8'h7a
`define FSCP_OP_ENTER_QUAD_CMD 8'h38
`define FSCP_OP_EXIT_QUAD_CMD 8'hff

// ----------------------------------------------------------------------------
// Field positions inside status byte one (S7..S0)
// ----------------------------------------------------------------------------
`define FSCP_S1_WEL_BIT 1
`define FSCP_S1_PM_LO_BIT 7

// ----------------------------------------------------------------------------
// Field positions inside status byte two (S15..S8)
// ----------------------------------------------------------------------------
`define FSCP_S2_PM_HI_BIT 0
`define FSCP_S2_QE_BIT 1
`define FSCP_S2_LOCK_LSB 3
`define FSCP_S2_LOCK_MSB 5
`define FSCP_S2_SUS_BIT 7

// ----------------------------------------------------------------------------
// Field positions inside status byte three (S23..S16)
// ----------------------------------------------------------------------------
`define FSCP_S3_DC_LSB 0
`define FSCP_S3_DC_MSB 1
`define FSCP_S3_DRV_LSB 5
`define FSCP_S3_DRV_MSB 6
`define FSCP_S3_PINFN_BIT 7

// ----------------------------------------------------------------------------
// Factory reset values and protect modes
// ----------------------------------------------------------------------------
`define FSCP_PM_SOFTWARE 2'h0
`define FSCP_PM_HARDWARE 2'h1
`define FSCP_PM_LOCKDOWN 2'h2
`define FSCP_PM_OTP 2'h3
`define FSCP_RST_DRV 2'h1
`define FSCP_RST_DC 2'h0
`define FSCP_RST_PINFN 1'h0
`define FSCP_RST_QE 1'h0

// ----------------------------------------------------------------------------
// Dummy clock counts
// ----------------------------------------------------------------------------
`define FSCP_DUMMY_8 4'h8
`define FSCP_DUMMY_4 4'h4
`define FSCP_DUMMY_6 4'h6
`define FSCP_DUMMY_10 4'ha

`endif

// ===== design/fscp_status_config.v
// Status, configuration and protection registers of a serial flash, reached over its SPI/FOUR_LINE_COMMAND_MODE pins.
`timescale 1ns/1ps
`default_nettype none
`include "fscp_consts.vh"
// Function
// - Protect mode 00 ignores the protect pin; write accepted when write latch set.
// - Protect mode 01 with protect pin low rejects every status write.
// - Protect mode 01 with protect pin high accepts writes only with latch set.
// - Protect mode 10 blocks writes until power cycle, which restores mode 00.
// - Protect mode 11 refuses all status writes until power cycle, which restores mode 00.
// - Protect mode bits are readable, writable bits at S8 and S7.
// - Suspend instruction 75h sets the read-only suspend flag at S15.
// - Resume instruction 7Ah and power cycle clear the suspend flag.
// - Three lock bits S13..S11 default 0, set individually, cleared only by power cycle.
// - A set lock bit makes its security register read-only until power cycle.
// - Quad enable at S9; 0 enables protect/pause, 1 makes pins data lines.
// - Enter four-line command mode 38h ignored while quad enable is 0.
// - In four-line command mode quad enable stays 1 despite status writes.
// - Two-bit drive strength: 00 100%, 01 75% default, 10 50%, 11 25%.
// - Pin-function bit: 0 pause input default, 1 active-low reset input.
// - Pause or reset role applies only while quad enable is 0.
// - Dummy select default 00; fast, dual and quad output reads use 8.
// - Dual and quad word reads 4/8/4/8; quad I/O read 6/4/8/10.
// - Reserved bits read zero and writes to them have no effect.
// - Write latch set by 06h, cleared by 04h, status writes and power-up.
module fscp_status_config (
  input wire mclk,
  input wire sys_rst,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire [3:0] dq_in,
  output reg [3:0] dq_out,
  output reg [3:0] dq_oe,
  output reg four_line_command_mode,
  output reg suspend_flag,
  output reg [2:0] sec_reg_read_only,
  output reg [1:0] drive_strength,
  output reg pause_active,
  output reg pin_reset_active,
  output reg [3:0] dummy_fast_read,
  output reg [3:0] dummy_dual_io_read,
  output reg [3:0] dummy_quad_io_read
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [5:0] pin_meta_reg;
  reg [5:0] pin_sync_reg;
  reg sclk_prev_reg;
  wire sclk_s = pin_sync_reg[5];
  wire cs_n_s = pin_sync_reg[4];
  wire [3:0] dq_s = pin_sync_reg[3:0];

  // All pins come from the link domain, so each passes two flip-flops first.
  always @(posedge mclk) begin
    if (sys_rst) begin
      pin_meta_reg <= 6'h1c; // Idle pin levels, so no false edge or pause follows reset.
      pin_sync_reg <= 6'h1c;
      sclk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {spi_clk, spi_cs_n, dq_in};
      pin_sync_reg <= pin_meta_reg;
      sclk_prev_reg <= sclk_s;
    end
  end

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg [1:0] protect_mode_reg;
  reg write_enable_latch_reg;
  reg quad_io_enable_reg;
  reg [2:0] security_lock_reg;
  reg [1:0] wait_cycle_sel_reg;
  reg pin_function_reg;
  reg cs_prev_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] byte_idx_reg;
  reg [7:0] opcode_reg;
  reg [7:0] data1_reg;
  reg [7:0] data2_reg;
  reg [7:0] out_shift_reg;
  reg [3:0] out_cnt_reg;
  reg reading_reg;
  reg [7:0] read_value_reg;
  reg adv_pending_reg;

  // Protect pin and shared pin roles exist only while quad enable is 0.
  wire wp_pin_high = quad_io_enable_reg | dq_s[2];
  wire pause_now = ~quad_io_enable_reg & ~pin_function_reg & ~dq_s[3];
  wire hw_reset_now = ~quad_io_enable_reg & pin_function_reg & ~dq_s[3];
  wire sclk_rise = sclk_s & ~sclk_prev_reg;
  wire sclk_fall = ~sclk_s & sclk_prev_reg;
  wire cs_rise = cs_n_s & ~cs_prev_reg;
  wire active = ~cs_n_s & ~pause_now;
  wire [3:0] step = four_line_command_mode ? 4'h4 : 4'h1;
  wire [7:0] shift_next = four_line_command_mode ? {shift_reg[3:0], dq_s} : {shift_reg[6:0], dq_s[0]};
  wire [3:0] bit_cnt_next = bit_cnt_reg + step;
  wire byte_done = active & sclk_rise & (bit_cnt_next == 4'h8);

  // Status byte images; reserved and out-of-scope bits read as zero.
  wire [7:0] stat1_img = {protect_mode_reg[0], 5'h00, write_enable_latch_reg, 1'b0};
  wire [7:0] stat2_img = {suspend_flag, 1'b0, security_lock_reg, 1'b0, quad_io_enable_reg,
                          protect_mode_reg[1]};
  wire [7:0] stat3_img = {pin_function_reg, drive_strength, 3'h0, wait_cycle_sel_reg};

  // Write acceptance depends on protect mode, protect pin and write latch.
  function wr_allowed;
    input [1:0] mode;
    input wp_high;
    input latch;
    begin
      case (mode)
        `FSCP_PM_SOFTWARE: wr_allowed = latch;
        `FSCP_PM_HARDWARE: wr_allowed = latch & wp_high;
        `FSCP_PM_LOCKDOWN: wr_allowed = 1'b0;
        default: wr_allowed = 1'b0;
      endcase
    end
  endfunction

  // Quad I/O fast read dummy count from the dummy select code.
  function [3:0] quad_io_dummy;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: quad_io_dummy = `FSCP_DUMMY_6;
        2'h1: quad_io_dummy = `FSCP_DUMMY_4;
        2'h2: quad_io_dummy = `FSCP_DUMMY_8;
        default: quad_io_dummy = `FSCP_DUMMY_10;
      endcase
    end
  endfunction

  // Image of a status byte selected by its read opcode.
  function [7:0] read_image;
    input [7:0] op;
    input [7:0] s1;
    input [7:0] s2;
    input [7:0] s3;
    begin
      case (op)
        `FSCP_OP_RD_STAT1: read_image = s1;
        `FSCP_OP_RD_STAT2: read_image = s2;
        default: read_image = s3;
      endcase
    end
  endfunction

  wire is_read_op = (shift_next == `FSCP_OP_RD_STAT1) | (shift_next == `FSCP_OP_RD_STAT2) |
                    (shift_next == `FSCP_OP_RD_STAT3);
  wire frame_ok = cs_rise & (bit_cnt_reg == 4'h0);
  wire one_byte = frame_ok & (byte_idx_reg == 2'h1);
  wire is_wr_stat = (opcode_reg == `FSCP_OP_WR_STAT1) | (opcode_reg == `FSCP_OP_WR_STAT2) |
                    (opcode_reg == `FSCP_OP_WR_STAT3);
  wire wr_frame = frame_ok & (byte_idx_reg != 2'h0) & (byte_idx_reg != 2'h1) & is_wr_stat;
  wire wr_ok = wr_frame & wr_allowed(protect_mode_reg, wp_pin_high, write_enable_latch_reg);

  // --------------------------------------------------------------------------
  // Frame receiver: shifts bits or nibbles on the link clock's rising edges
  // --------------------------------------------------------------------------
  // Bytes are collected only while chip select is low and no pause is held.
  always @(posedge mclk) begin
    if (sys_rst | hw_reset_now) begin
      cs_prev_reg <= 1'b1;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      opcode_reg <= 8'h00;
      data1_reg <= 8'h00;
      data2_reg <= 8'h00;
    end else begin
      cs_prev_reg <= cs_n_s;
      if (cs_n_s) begin
        bit_cnt_reg <= 4'h0;
        if (cs_rise)
          byte_idx_reg <= byte_idx_reg;
        else
          byte_idx_reg <= 2'h0;
      end else if (active & sclk_rise) begin
        shift_reg <= shift_next;
        if (byte_done) begin
          bit_cnt_reg <= 4'h0;
          if (byte_idx_reg != 2'h3)
            byte_idx_reg <= byte_idx_reg + 2'h1;
          if (byte_idx_reg == 2'h0)
            opcode_reg <= shift_next;
          else if (byte_idx_reg == 2'h1)
            data1_reg <= shift_next;
          else if (byte_idx_reg == 2'h2)
            data2_reg <= shift_next;
        end else begin
          bit_cnt_reg <= bit_cnt_next;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Volatile state: write latch, suspend flag, command mode
  // --------------------------------------------------------------------------
  // The reset pin clears write latch and command mode but leaves the suspend flag and stored configuration intact.
  always @(posedge mclk) begin
    if (sys_rst | hw_reset_now) begin
      write_enable_latch_reg <= 1'b0;
      four_line_command_mode <= 1'b0;
      if (sys_rst)
        suspend_flag <= 1'b0;
    end else begin
      if (one_byte & (opcode_reg == `FSCP_OP_WR_ENABLE))
        write_enable_latch_reg <= 1'b1;
      else if ((one_byte & (opcode_reg == `FSCP_OP_WR_DISABLE)) | wr_frame)
        write_enable_latch_reg <= 1'b0;
      if (one_byte & (opcode_reg == `FSCP_OP_SUSPEND))
        suspend_flag <= 1'b1;
      else if (one_byte & (opcode_reg == `FSCP_OP_RESUME))
        suspend_flag <= 1'b0;
      if (one_byte & (opcode_reg == `FSCP_OP_ENTER_QUAD_CMD) & quad_io_enable_reg)
        four_line_command_mode <= 1'b1;
      else if (one_byte & (opcode_reg == `FSCP_OP_EXIT_QUAD_CMD))
        four_line_command_mode <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Stored configuration, updated only by an accepted status write
  // --------------------------------------------------------------------------
  // Power-up returns every stored field to its factory value, lockdown included.
  always @(posedge mclk) begin
    if (sys_rst) begin
      protect_mode_reg <= `FSCP_PM_SOFTWARE;
      quad_io_enable_reg <= `FSCP_RST_QE;
      security_lock_reg <= 3'h0;
      drive_strength <= `FSCP_RST_DRV;
      wait_cycle_sel_reg <= `FSCP_RST_DC;
      pin_function_reg <= `FSCP_RST_PINFN;
    end else if (wr_ok) begin
      if (opcode_reg == `FSCP_OP_WR_STAT1) begin
        protect_mode_reg[0] <= data1_reg[`FSCP_S1_PM_LO_BIT];
      end
      if (((opcode_reg == `FSCP_OP_WR_STAT1) & (byte_idx_reg == 2'h3)) | (opcode_reg == `FSCP_OP_WR_STAT2)) begin
        // Data byte for status two is the second byte after 01h, else the first.
        protect_mode_reg[1] <= (opcode_reg == `FSCP_OP_WR_STAT1) ? data2_reg[`FSCP_S2_PM_HI_BIT]
                                                                  : data1_reg[`FSCP_S2_PM_HI_BIT];
        quad_io_enable_reg <= four_line_command_mode |
                              ((opcode_reg == `FSCP_OP_WR_STAT1) ? data2_reg[`FSCP_S2_QE_BIT]
                                                                : data1_reg[`FSCP_S2_QE_BIT]);
        security_lock_reg <= security_lock_reg |
                             ((opcode_reg == `FSCP_OP_WR_STAT1) ? data2_reg[`FSCP_S2_LOCK_MSB:`FSCP_S2_LOCK_LSB]
                                                               : data1_reg[`FSCP_S2_LOCK_MSB:`FSCP_S2_LOCK_LSB]);
      end
      if (opcode_reg == `FSCP_OP_WR_STAT3) begin
        wait_cycle_sel_reg <= data1_reg[`FSCP_S3_DC_MSB:`FSCP_S3_DC_LSB];
        drive_strength <= data1_reg[`FSCP_S3_DRV_MSB:`FSCP_S3_DRV_LSB];
        pin_function_reg <= data1_reg[`FSCP_S3_PINFN_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status read path: loads on the opcode's last rising edge, shifts after falls
  // --------------------------------------------------------------------------
  // The first falling edge after loading must not shift, or bit seven is lost.
  always @(posedge mclk) begin
    if (sys_rst | hw_reset_now | cs_n_s) begin
      reading_reg <= 1'b0;
      out_shift_reg <= 8'h00;
      out_cnt_reg <= 4'h0;
      read_value_reg <= 8'h00;
      adv_pending_reg <= 1'b0;
    end else if (active & sclk_rise) begin
      if (byte_done & (byte_idx_reg == 2'h0) & is_read_op) begin
        reading_reg <= 1'b1;
        read_value_reg <= read_image(shift_next, stat1_img, stat2_img, stat3_img);
        out_shift_reg <= read_image(shift_next, stat1_img, stat2_img, stat3_img);
        out_cnt_reg <= 4'h0;
        adv_pending_reg <= 1'b0;
      end else if (reading_reg) begin
        adv_pending_reg <= 1'b1;
      end
    end else if (active & sclk_fall & adv_pending_reg) begin
      adv_pending_reg <= 1'b0;
      if (out_cnt_reg + step == 4'h8) begin
        // Repeated reads return a fresh image of the same byte.
        out_cnt_reg <= 4'h0;
        out_shift_reg <= read_image(opcode_reg, stat1_img, stat2_img, stat3_img);
      end else begin
        out_cnt_reg <= out_cnt_reg + step;
        out_shift_reg <= four_line_command_mode ? {out_shift_reg[3:0], 4'h0} : {out_shift_reg[6:0], 1'b0};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs: pins, pin roles, locks and dummy counts
  // --------------------------------------------------------------------------
  // Drive data from flops; a held pause floats the lines as the pin role asks.
  always @(posedge mclk) begin
    if (sys_rst) begin
      dq_out <= 4'h0;
      dq_oe <= 4'h0;
      pause_active <= 1'b0;
      pin_reset_active <= 1'b0;
      sec_reg_read_only <= 3'h0;
      dummy_fast_read <= `FSCP_DUMMY_8;
      dummy_dual_io_read <= `FSCP_DUMMY_4;
      dummy_quad_io_read <= `FSCP_DUMMY_6;
    end else begin
      if (reading_reg & active & four_line_command_mode) begin
        dq_out <= out_shift_reg[7:4];
        dq_oe <= 4'hf;
      end else if (reading_reg & active) begin
        dq_out <= {2'h0, out_shift_reg[7], 1'b0};
        dq_oe <= 4'h2;
      end else begin
        dq_out <= 4'h0;
        dq_oe <= 4'h0;
      end
      pause_active <= pause_now & ~cs_n_s;
      pin_reset_active <= hw_reset_now;
      sec_reg_read_only <= security_lock_reg;
      dummy_fast_read <= `FSCP_DUMMY_8;
      dummy_dual_io_read <= wait_cycle_sel_reg[0] ? `FSCP_DUMMY_8 : `FSCP_DUMMY_4;
      dummy_quad_io_read <= quad_io_dummy(wait_cycle_sel_reg);
    end
  end

endmodule // fscp_status_config
`default_nettype wire

// ===== dv/fscp_status_config_assertions.sv
// Concurrent checks on the flash status, configuration and protection block.
`timescale 1ns/1ps
`default_nettype none
module fscp_chk (
  input wire mclk,
  input wire sys_rst,
  input wire spi_clk,
  input wire spi_cs_n,
  input wire [3:0] dq_in,
  input wire [3:0] dq_out,
  input wire [3:0] dq_oe,
  input wire four_line_command_mode,
  input wire suspend_flag,
  input wire [2:0] sec_reg_read_only,
  input wire [1:0] drive_strength,
  input wire pause_active,
  input wire pin_reset_active,
  input wire [3:0] dummy_fast_read,
  input wire [3:0] dummy_dual_io_read,
  input wire [3:0] dummy_quad_io_read
);
  default clocking cb @(posedge mclk); endclocking
  // Stored fields move only once a frame has closed, or straight after a reset.
  sequence s_after_frame;
    $past(spi_cs_n, 3) || $past(sys_rst);
  endsequence
  sequence s_cs_idle;
    spi_cs_n [*7];
  endsequence
  property p_rst_vals;
    sys_rst |=> drive_strength == 2'h1 && dummy_quad_io_read == 4'h6 && !suspend_flag && sec_reg_read_only == 3'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_fast_fixed;
    disable iff (sys_rst) 1'b1 |-> dummy_fast_read == 4'h8;
  endproperty
  a_fast_fixed: assert property (p_fast_fixed) else $error("fast read dummies not eight");
  property p_dual_sel;
    disable iff (sys_rst) dummy_dual_io_read == ((dummy_quad_io_read == 4'h4 || dummy_quad_io_read == 4'ha) ? 4'h8 : 4'h4);
  endproperty
  a_dual_sel: assert property (p_dual_sel) else $error("dual dummies disagree with quad dummies");
  property p_quad_set;
    disable iff (sys_rst) dummy_quad_io_read inside {4'h4, 4'h6, 4'h8, 4'ha};
  endproperty
  a_quad_set: assert property (p_quad_set) else $error("quad dummies out of table");
  property p_cfg_at_end;
    disable iff (sys_rst) $changed({drive_strength, suspend_flag, dummy_quad_io_read}) |-> s_after_frame;
  endproperty
  a_cfg_at_end: assert property (p_cfg_at_end) else $error("field changed inside a frame");
  property p_mode_at_end;
    disable iff (sys_rst) $rose(four_line_command_mode) |-> s_after_frame;
  endproperty
  a_mode_at_end: assert property (p_mode_at_end) else $error("four-line mode entered inside a frame");
  property p_lock_keep;
    disable iff (sys_rst) $changed(sec_reg_read_only) |-> (sec_reg_read_only & $past(sec_reg_read_only)) == $past(sec_reg_read_only) || $past(sys_rst);
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared");
  property p_oe_idle;
    disable iff (sys_rst) s_cs_idle |-> dq_oe == 4'h0;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data lines driven while deselected");
  property p_oe_shape;
    disable iff (sys_rst) dq_oe != 4'h0 |-> (dq_oe == 4'h2 && !four_line_command_mode) || (dq_oe == 4'hf && four_line_command_mode);
  endproperty
  a_oe_shape: assert property (p_oe_shape) else $error("wrong lines driven");
  property p_roles;
    disable iff (sys_rst) pause_active || pin_reset_active |-> !four_line_command_mode && !(pause_active && pin_reset_active);
  endproperty
  a_roles: assert property (p_roles) else $error("pin role active with quad lines in use");
endmodule // fscp_chk
bind fscp_status_config fscp_chk i_chk (.mclk(mclk), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .four_line_command_mode(four_line_command_mode),
  .suspend_flag(suspend_flag), .sec_reg_read_only(sec_reg_read_only), .drive_strength(drive_strength),
  .pause_active(pause_active), .pin_reset_active(pin_reset_active), .dummy_fast_read(dummy_fast_read),
  .dummy_dual_io_read(dummy_dual_io_read), .dummy_quad_io_read(dummy_quad_io_read));
`default_nettype wire

// ===== dv/fscp_host_model.sv
// Behavioural host controller that sends serial frames to the flash block.
`timescale 1ns/1ps
`default_nettype none
module fscp_host_model (
  input wire logic mclk,
  output logic spi_clk,
  output logic spi_cs_n,
  output logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe
);
  logic quad = 1'b0;
  logic wp_n = 1'b1;
  logic hold_n = 1'b1;
  logic [3:0] drv = 4'h5;
  // A line shows the device's value while it drives, else the host's.
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & (quad ? drv : {hold_n, wp_n, drv[1:0]}));
  // The link clock stands low and the chip is deselected between frames.
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One link period of 64 ns; read data is taken mid high phase.
  task automatic tick(output logic v);
    w(4);
    spi_clk = 1'b1;
    w(2);
    v = dq_out[1];
    w(2);
    spi_clk = 1'b0;
  endtask
  task automatic put(input logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i -= (quad ? 4 : 1)) begin
      if (quad) drv = b[i -: 4];
      else drv[0] = b[i];
      tick(v);
    end
  endtask
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick(b[i]);
  endtask
  task automatic go();
    spi_cs_n = 1'b0;
    w(4);
  endtask
  // Released lines flip so that a stale value is never mistaken for data.
  task automatic fin();
    w(4);
    spi_cs_n = 1'b1;
    drv = ~drv;
    w(12);
  endtask
endmodule // fscp_host_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the flash status, configuration and protection block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic spi_clk, spi_cs_n, four_line_command_mode, suspend_flag, pause_active, pin_reset_active;
  logic [3:0] dq_in, dq_out, dq_oe, dummy_fast_read, dummy_dual_io_read, dummy_quad_io_read;
  logic [2:0] sec_reg_read_only;
  logic [1:0] drive_strength;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  fscp_status_config i_dut (.mclk(mclk), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .four_line_command_mode(four_line_command_mode),
    .suspend_flag(suspend_flag), .sec_reg_read_only(sec_reg_read_only), .drive_strength(drive_strength),
    .pause_active(pause_active), .pin_reset_active(pin_reset_active), .dummy_fast_read(dummy_fast_read),
    .dummy_dual_io_read(dummy_dual_io_read), .dummy_quad_io_read(dummy_quad_io_read));
  fscp_host_model i_host (.mclk(mclk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));
  // ------
  // Helpers
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.go();
    i_host.put(op);
    i_host.fin();
  endtask
  task automatic wr(input logic en, input logic [7:0] op, input logic [7:0] d);
    if (en) cmd(8'h06);
    i_host.go();
    i_host.put(op);
    i_host.put(d);
    i_host.fin();
  endtask
  task automatic wr01(input logic [7:0] a, input logic [7:0] b);
    cmd(8'h06);
    i_host.go();
    i_host.put(8'h01);
    i_host.put(a);
    i_host.put(b);
    i_host.fin();
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] mask, input logic [7:0] exp, input string m);
    logic [7:0] b;
    i_host.go();
    i_host.put(op);
    i_host.get(b);
    i_host.fin();
    chk(b & mask, exp, m);
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    i_host.w(2);
    sys_rst = 1'b0;
    i_host.w(4);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_config();
    logic [1:0] k;
    logic [3:0] q;
    chk({dummy_fast_read, dummy_quad_io_read}, 8'h86, "reset dummies");
    rd(8'h35, 8'hff, 8'h00, "reset status two");
    rd(8'h15, 8'hff, 8'h20, "reset status three");
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      q = (k == 2'h0) ? 4'h6 : (k == 2'h1) ? 4'h4 : (k == 2'h2) ? 4'h8 : 4'ha;
      wr(1'b1, 8'h11, {1'b0, ~k, 3'h7, k});
      chk({2'h0, drive_strength, dummy_dual_io_read}, {2'h0, ~k, k[0] ? 4'h8 : 4'h4}, "drive and dual");
      chk({dummy_fast_read, dummy_quad_io_read}, {4'h8, q}, "fast and quad dummies");
      rd(8'h15, 8'hff, {1'b0, ~k, 3'h0, k}, "status three");
    end
    wr(1'b0, 8'h11, 8'h20);
    chk({6'h0, drive_strength}, 8'h00, "write without latch");
    $display("test config done");
  endtask
  task automatic t_protect();
    wr01(8'h80, 8'h00);
    rd(8'h05, 8'h80, 8'h80, "protect low bit");
    i_host.wp_n = 1'b0;
    wr(1'b1, 8'h11, 8'h60);
    chk({6'h0, drive_strength}, 8'h00, "write with pin low");
    rd(8'h05, 8'h02, 8'h00, "latch after refused write");
    i_host.wp_n = 1'b1;
    wr(1'b0, 8'h11, 8'h60);
    chk({6'h0, drive_strength}, 8'h00, "pin high no latch");
    wr(1'b1, 8'h11, 8'h60);
    chk({6'h0, drive_strength}, 8'h03, "pin high with latch");
    wr01(8'h00, 8'h01);
    rd(8'h35, 8'h01, 8'h01, "protect high bit");
    wr(1'b1, 8'h11, 8'h00);
    chk({6'h0, drive_strength}, 8'h03, "write in lock-down");
    do_reset();
    rd(8'h35, 8'h01, 8'h00, "lock-down after power cycle");
    wr01(8'h80, 8'h01);
    wr01(8'h00, 8'h00);
    rd(8'h35, 8'h01, 8'h01, "write in permanent mode");
    do_reset();
    $display("test protect done");
  endtask
  task automatic t_flags();
    cmd(8'h06);
    rd(8'h05, 8'h02, 8'h02, "latch after enable");
    cmd(8'h04);
    rd(8'h05, 8'h02, 8'h00, "latch after disable");
    cmd(8'h75);
    chk({7'h0, suspend_flag}, 8'h01, "suspend set");
    wr(1'b1, 8'h31, 8'h00);
    rd(8'h35, 8'h80, 8'h80, "suspend read-only");
    cmd(8'h7a);
    chk({7'h0, suspend_flag}, 8'h00, "resume");
    cmd(8'h75);
    do_reset();
    chk({7'h0, suspend_flag}, 8'h00, "suspend after power cycle");
    wr(1'b1, 8'h31, 8'h08);
    chk({5'h0, sec_reg_read_only}, 8'h01, "first lock");
    wr(1'b1, 8'h31, 8'h10);
    wr(1'b1, 8'h31, 8'h00);
    chk({5'h0, sec_reg_read_only}, 8'h03, "locks kept");
    rd(8'h35, 8'h38, 8'h18, "lock bits");
    $display("test flags done");
  endtask
  task automatic t_quad();
    i_host.hold_n = 1'b0;
    i_host.go();
    i_host.w(4);
    chk({7'h0, pause_active}, 8'h01, "pause with quad off");
    i_host.hold_n = 1'b1;
    i_host.fin();
    cmd(8'h38);
    chk({7'h0, four_line_command_mode}, 8'h00, "enter with quad off");
    wr(1'b1, 8'h31, 8'h02);
    i_host.hold_n = 1'b0;
    i_host.go();
    i_host.w(4);
    chk({7'h0, pause_active}, 8'h00, "pause with quad on");
    i_host.hold_n = 1'b1;
    i_host.fin();
    cmd(8'h38);
    chk({7'h0, four_line_command_mode}, 8'h01, "enter with quad on");
    i_host.quad = 1'b1;
    wr(1'b1, 8'h31, 8'h00);
    cmd(8'hff);
    i_host.quad = 1'b0;
    cmd(8'h38);
    chk({7'h0, four_line_command_mode}, 8'h01, "quad kept in four-line mode");
    i_host.quad = 1'b1;
    cmd(8'hff);
    i_host.quad = 1'b0;
    wr(1'b1, 8'h31, 8'h00);
    wr(1'b1, 8'h11, 8'h80);
    i_host.hold_n = 1'b0;
    i_host.w(8);
    chk({7'h0, pin_reset_active}, 8'h01, "reset role");
    i_host.hold_n = 1'b1;
    rd(8'h15, 8'hff, 8'h80, "fields after pin reset");
    $display("test quad done");
  endtask
  // ------
  // Closing and watchdog
  // ------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The run needs under 15000 cycles; the ceiling leaves ample margin.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("wrong value at %0t: timeout", $time);
      stop_test();
    end
  end
  initial begin
    i_host.w(2);
    sys_rst = 1'b0;
    i_host.w(4);
    t_config();
    t_protect();
    t_flags();
    t_quad();
    stop_test();
  end
endmodule // tb
`default_nettype wire
